// *** timer_pkg.sv ***
// constants for the prescaled timer with capture, compare and pwm channels
// assumes a 32-bit ahb-lite slave port, one word per register
package timer_pkg;
   localparam int ADDR_W = 5;
   localparam int PRE_W  = 6;
   localparam int CNT_W  = 16;
   localparam int NCHAN  = 2;

   // register byte offsets
   localparam logic [4:0] OFS_TIMER_CTL = 5'h00;
   localparam logic [4:0] OFS_COUNT     = 5'h04;
   localparam logic [4:0] OFS_PERIOD    = 5'h08;
   localparam logic [4:0] OFS_CH0_CTL   = 5'h0c;
   localparam logic [4:0] OFS_CH0_VAL   = 5'h10;
   localparam logic [4:0] OFS_CH1_CTL   = 5'h14;
   localparam logic [4:0] OFS_CH1_VAL   = 5'h18;

   // timer_control_status bits
   localparam int TC_FLAG  = 7;
   localparam int TC_IE    = 6;
   localparam int TC_HALT  = 5;
   localparam int TC_CLEAR = 4;
   localparam int TC_DIV   = 0;

   // channel_control_status bits
   localparam int CC_FLAG  = 7;
   localparam int CC_IE    = 6;
   localparam int CC_MODEB = 5;
   localparam int CC_MODEA = 4;
   localparam int CC_EDGE  = 2;
   localparam int CC_TOV   = 1;
   localparam int CC_MAX   = 0;

   localparam logic [2:0]  DIV_MAX      = 3'h6;
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   localparam logic        HALT_RESET   = 1'b1;

   // edge_level_bits: capture edge or compare action
   localparam logic [1:0] EDGE_NONE  = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;
endpackage

// *** timer_capture_compare_pwm.sv ***
// timer unit: prescaler, modulo counter, two capture/compare/pwm channels
// assumes an ahb-lite master on clock, pins asynchronous to clock
`timescale 1ns/1ps

// Functional notes
// - prescaler offers seven rates; three-bit select picks the counting rate
// - active pin edge in capture mode copies counter into channel value
// - capture edge chosen by the channel edge/level bits
// - capture or compare sets channel flag; enabled flag raises interrupt
// - compare match sets, clears or toggles pin per configured action
// - unbuffered value write acts at once; a passed value misses that period
// - link bit on channel 0 pairs channels onto channel 0 pin
// - channel 0 values lead; last written set takes over at overflow
// - linked: channel 0 control governs, channel 1 pin becomes plain io
// - toggle-on-overflow toggles pin at modulo, giving pwm period
// - pulse runs overflow to match; clear or set action picks polarity
// - modulo 00ff undivided gives 256-clock period; count 0..modulo
// - toggle-on-overflow off leaves pin idle, giving 0% duty
// - full-duty bit with toggle-on-overflow gives constant 100% duty
// - counter at modulo sets overflow flag, restarts from zero
// - select codes 0..6 divide by 1..64; code 7 never counts
// - self-clearing clear bit zeroes counter and prescaler only
module timer_capture_compare_pwm (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [1:0]  chan_pin_in,
   output logic      [1:0]  chan_pin_out,
   output logic      [1:0]  chan_pin_oe,
   output logic             overflow_irq,
   output logic      [1:0]  chan_irq
);
   localparam int N = timer_pkg::NCHAN;

   // bus data-phase state
   logic                     wr_q, wr_d;
   logic [timer_pkg::ADDR_W-1:0] wa_q, wa_d;
   logic [31:0]              rd_q, rd_d;
   // timer state
   logic [timer_pkg::PRE_W-1:0] pre_q, pre_d;
   logic [15:0]              cnt_q, cnt_d, period_q, period_d;
   logic [2:0]               div_q, div_d;
   logic                     halt_q, halt_d, ovie_q, ovie_d;
   logic                     tof_q, tof_d, tof_arm_q, tof_arm_d;
   // channel state
   logic [N-1:0][6:0]        cc_q, cc_d;
   logic [N-1:0][15:0]       val_q, val_d;
   logic [N-1:0]             chf_q, chf_d, chf_arm_q, chf_arm_d;
   logic [N-1:0]             pin_q, pin_d;
   logic [N-1:0]             sync1_q, sync2_q, prev_q;
   logic                     act_q, act_d, last_q, last_d;
   // combinational terms
   logic                     addr_ok, tick, ovf, clr, linked;
   logic [timer_pkg::PRE_W-1:0] mask;
   logic [15:0]              cnt_nx;
   logic [N-1:0]             cap, cmp, cap_ev, match;
   logic [N-1:0][15:0]       cmp_val;
   logic [N-1:0][1:0]        edge_sel;

   assign hrdata    = rd_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ok   = hsel && htrans[1] && hready;
   assign linked    = cc_q[0][timer_pkg::CC_MODEB];

   always_comb begin
      logic wsel_ctl;
      wsel_ctl = wr_q && (wa_q == timer_pkg::OFS_TIMER_CTL);
      clr      = wsel_ctl && hwdata[timer_pkg::TC_CLEAR];
      // power-of-two divide: tick when the low prescaler bits are all ones
      mask   = timer_pkg::PRE_W'((7'h1 << div_q) - 7'h1);
      tick   = !halt_q && (div_q <= timer_pkg::DIV_MAX) && ((pre_q & mask) == mask);
      cnt_nx = (cnt_q == period_q) ? 16'h0000 : cnt_q + 16'h0001;
      ovf    = tick && (cnt_q == period_q);

      wr_d = addr_ok && hwrite;
      wa_d = addr_ok ? haddr[timer_pkg::ADDR_W-1:0] : wa_q;
      rd_d = rd_q;
      pre_d = halt_q ? pre_q : pre_q + timer_pkg::PRE_W'(1);
      cnt_d = tick ? cnt_nx : cnt_q;
      if (clr) begin
         pre_d = '0;
         cnt_d = '0;
      end
      period_d  = period_q;
      div_d     = div_q;
      halt_d    = halt_q;
      ovie_d    = ovie_q;
      tof_arm_d = tof_arm_q;
      cc_d      = cc_q;
      val_d     = val_q;
      chf_arm_d = chf_arm_q;
      last_d    = last_q;
      tof_d     = tof_q;

      // register writes in the data phase
      if (wsel_ctl) begin
         div_d     = hwdata[timer_pkg::TC_DIV +: 3];
         halt_d    = hwdata[timer_pkg::TC_HALT];
         ovie_d    = hwdata[timer_pkg::TC_IE];
         tof_arm_d = 1'b0;
         // two-step clear: only a write of zero after a read seeing the flag
         if (tof_arm_q && !hwdata[timer_pkg::TC_FLAG])
            tof_d = 1'b0;
      end
      if (ovf)
         tof_d = 1'b1;
      if (wr_q && wa_q == timer_pkg::OFS_PERIOD)
         period_d = hwdata[15:0];
      chf_d = chf_q;
      for (int i = 0; i < N; i++) begin
         if (wr_q && wa_q == (i == 0 ? timer_pkg::OFS_CH0_CTL : timer_pkg::OFS_CH1_CTL)) begin
            cc_d[i]      = hwdata[6:0];
            chf_arm_d[i] = 1'b0;
            if (chf_arm_q[i] && !hwdata[timer_pkg::CC_FLAG])
               chf_d[i] = 1'b0;
         end
         if (wr_q && wa_q == (i == 0 ? timer_pkg::OFS_CH0_VAL : timer_pkg::OFS_CH1_VAL)) begin
            val_d[i] = hwdata[15:0];
            last_d   = (i != 0);
         end
      end

      // register reads sampled in the address phase
      if (addr_ok && !hwrite) begin
         unique case (haddr[timer_pkg::ADDR_W-1:0])
            timer_pkg::OFS_TIMER_CTL: begin
               rd_d = {24'h0, tof_q, ovie_q, halt_q, 2'b00, div_q};
               tof_arm_d = tof_q;
            end
            timer_pkg::OFS_COUNT:  rd_d = {16'h0, cnt_q};
            timer_pkg::OFS_PERIOD: rd_d = {16'h0, period_q};
            timer_pkg::OFS_CH0_CTL: begin
               rd_d = {24'h0, chf_q[0], cc_q[0]};
               chf_arm_d[0] = chf_q[0];
            end
            timer_pkg::OFS_CH1_CTL: begin
               rd_d = {24'h0, chf_q[1], cc_q[1]};
               chf_arm_d[1] = chf_q[1];
            end
            timer_pkg::OFS_CH0_VAL: rd_d = {16'h0, val_q[0]};
            timer_pkg::OFS_CH1_VAL: rd_d = {16'h0, val_q[1]};
            default:                rd_d = 32'h0;
         endcase
      end

      // buffered pair: active set follows the last written set at overflow
      act_d = !linked ? 1'b0 : (ovf ? last_q : act_q);

      // channel behaviour
      for (int i = 0; i < N; i++) begin
         edge_sel[i] = cc_q[i][timer_pkg::CC_EDGE +: 2];
         if (i == 0) begin
            cmp[i] = cc_q[i][timer_pkg::CC_MODEB] | cc_q[i][timer_pkg::CC_MODEA];
            cap[i] = !cmp[i];
            cmp_val[i] = (linked && act_q) ? val_q[1] : val_q[0];
         end else begin
            // channel 1 is idle when paired with channel 0
            cmp[i] = cc_q[i][timer_pkg::CC_MODEA] && !linked;
            cap[i] = !cc_q[i][timer_pkg::CC_MODEA] && !linked;
            cmp_val[i] = val_q[i];
         end
         cap_ev[i] = cap[i] && ((edge_sel[i][0] && sync2_q[i] && !prev_q[i])
                     || (edge_sel[i][1] && !sync2_q[i] && prev_q[i]));
         match[i] = cmp[i] && tick && (cnt_nx == cmp_val[i]);
         if (cap_ev[i])
            val_d[i] = cnt_q;
         pin_d[i] = pin_q[i];
         if (cmp[i] && ovf && cc_q[i][timer_pkg::CC_TOV])
            pin_d[i] = !pin_q[i];
         // match after toggle so a zero width ends the pulse at once
         if (match[i]) begin
            unique case (edge_sel[i])
               timer_pkg::ACT_TOGGLE: pin_d[i] = !pin_d[i];
               timer_pkg::ACT_CLEAR:  pin_d[i] = 1'b0;
               timer_pkg::ACT_SET:    pin_d[i] = 1'b1;
               timer_pkg::EDGE_NONE:  pin_d[i] = pin_d[i];
            endcase
         end
         if (cmp[i] && cc_q[i][timer_pkg::CC_TOV] && cc_q[i][timer_pkg::CC_MAX])
            pin_d[i] = !edge_sel[i][0];
         if (cap_ev[i] || match[i])
            chf_d[i] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wr_q      <= 1'b0;
         wa_q      <= '0;
         rd_q      <= 32'h0;
         pre_q     <= '0;
         cnt_q     <= 16'h0;
         period_q  <= timer_pkg::PERIOD_RESET;
         div_q     <= 3'h0;
         halt_q    <= timer_pkg::HALT_RESET;
         ovie_q    <= 1'b0;
         tof_q     <= 1'b0;
         tof_arm_q <= 1'b0;
         cc_q      <= '0;
         val_q     <= '0;
         chf_q     <= '0;
         chf_arm_q <= '0;
         pin_q     <= '0;
         act_q     <= 1'b0;
         last_q    <= 1'b0;
      end else begin
         wr_q      <= wr_d;
         wa_q      <= wa_d;
         rd_q      <= rd_d;
         pre_q     <= pre_d;
         cnt_q     <= cnt_d;
         period_q  <= period_d;
         div_q     <= div_d;
         halt_q    <= halt_d;
         ovie_q    <= ovie_d;
         tof_q     <= tof_d;
         tof_arm_q <= tof_arm_d;
         cc_q      <= cc_d;
         val_q     <= val_d;
         chf_q     <= chf_d;
         chf_arm_q <= chf_arm_d;
         pin_q     <= pin_d;
         act_q     <= act_d;
         last_q    <= last_d;
      end
      // synchroniser keeps running through reset: no false edge after release
      sync1_q <= chan_pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
   end

   assign chan_pin_out = pin_q;
   assign overflow_irq = tof_q && ovie_q;
   for (genvar g = 0; g < N; g++) begin : g_chan
      assign chan_pin_oe[g] = cmp[g] && (edge_sel[g] != timer_pkg::EDGE_NONE);
      assign chan_irq[g]    = chf_q[g] && cc_q[g][timer_pkg::CC_IE];
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_tick_undivided:
      assert property ((div_q == 3'h0 && !halt_q) |-> tick)
      else $error("undivided select did not tick every clock");
   a_count_step:
      assert property ((tick && cnt_q != period_q && !clr) |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("counter did not step by one on a tick");
   a_wrap_flag:
      assert property ((ovf && !clr) |=> (cnt_q == 16'h0000) && tof_q)
      else $error("modulo reach did not wrap and flag");
   a_halt_holds:
      assert property ((halt_q && !clr) |-> (match == '0) ##1 $stable(cnt_q))
      else $error("halted counter moved or matched");
   a_clear_zeroes:
      assert property (clr |=> cnt_q == 16'h0000 && pre_q == '0 && $stable(period_q))
      else $error("clear bit did not zero counter and prescaler");
   a_capture_latch:
      assert property (cap_ev[0] |=> val_q[0] == $past(cnt_q))
      else $error("capture did not latch the count");
   a_set_action:
      assert property ((match[0] && edge_sel[0] == timer_pkg::ACT_SET && !cc_q[0][timer_pkg::CC_MAX])
                       |=> pin_q[0])
      else $error("set-on-compare left pin low");
   a_zero_duty:
      assert property ((cmp[0] && !cc_q[0][timer_pkg::CC_TOV] && edge_sel[0] == timer_pkg::ACT_CLEAR
                        && !pin_q[0] && $stable(cc_q[0])) |=> !pin_q[0])
      else $error("pin rose with overflow toggle off");
   a_full_duty:
      assert property ((cmp[0] && cc_q[0][timer_pkg::CC_TOV] && cc_q[0][timer_pkg::CC_MAX]
                        && edge_sel[0] == timer_pkg::ACT_CLEAR) |=> pin_q[0])
      else $error("full duty did not hold the pulse level");
   a_buffer_swap:
      assert property ((linked && ovf && $stable(cc_q[0])) |=> act_q == $past(last_q))
      else $error("active set not taken from last written at overflow");
   a_link_gpio:
      assert property (linked |-> !chan_pin_oe[1] && !cap_ev[1] && !match[1])
      else $error("channel 1 pin still driven while linked");
endmodule

// *** pin_load.sv ***
// loads and event sources on the two channel pins
// assumes the bench moves src_en and src_level just after a rising edge
`timescale 1ns/1ps
module pin_load (
   input  wire logic [1:0] chan_pin_out,
   input  wire logic [1:0] chan_pin_oe,
   input  wire logic [1:0] src_en,
   input  wire logic [1:0] src_level,
   output logic      [1:0] pin_level
);
   // pull-up on each pin: a released line reads 1, never a simulator guess
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin_level[i] = chan_pin_oe[i] ? chan_pin_out[i] : (src_en[i] ? src_level[i] : 1'b1);
      end
   end
endmodule

// *** test_timer_capture_compare_pwm.sv ***
// self-checking bench for the timer with capture, compare and pwm channels
// assumes timer_pkg and pin_load are compiled before it
`timescale 1ns/1ps
module test_timer_capture_compare_pwm;
   typedef struct {logic k; logic [31:0] a; logic [31:0] b; logic [31:0] e;} row_t;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [1:0]  chan_pin_out;
   logic [1:0]  chan_pin_oe;
   logic        overflow_irq;
   logic [1:0]  chan_irq;
   logic [1:0]  src_en = 2'h2;
   logic [1:0]  src_level = 2'h3;
   logic [1:0]  pin_level;
   int          fails = 0;
   int          compares = 0;
   logic [31:0] rd;
   // kind 0: timer control, count gained in 128 cycles; kind 1: width, control, high cycles
   row_t        rows [14] = '{
      '{1'b0, 32'h0, 32'h0, 32'd128}, '{1'b0, 32'h1, 32'h0, 32'd64},
      '{1'b0, 32'h2, 32'h0, 32'd32}, '{1'b0, 32'h3, 32'h0, 32'd16},
      '{1'b0, 32'h4, 32'h0, 32'd8}, '{1'b0, 32'h5, 32'h0, 32'd4},
      '{1'b0, 32'h6, 32'h0, 32'd2}, '{1'b0, 32'h7, 32'h0, 32'd0},
      '{1'b0, 32'h20, 32'h0, 32'd0}, '{1'b0, 32'h40, 32'h0, 32'd128},
      '{1'b1, 32'h80, 32'h1a, 32'd256}, '{1'b1, 32'h40, 32'h1e, 32'd384},
      '{1'b1, 32'h40, 32'h18, 32'd0}, '{1'b1, 32'h40, 32'h1b, 32'd512}};
   always #2 clock = ~clock;
   timer_capture_compare_pwm dut (
      .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .chan_pin_in(pin_level),
      .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
      .overflow_irq(overflow_irq), .chan_irq(chan_irq));
   pin_load load (.chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
      .src_en(src_en), .src_level(src_level), .pin_level(pin_level));
   task automatic results();
      if (fails == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic await_ready();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t bus wait timed out", $time);
         results();
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {27'h0, a};
      hwrite <= wr;
      await_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      await_ready();
      rd = hrdata;
   endtask
   // window of 512 cycles spans two whole periods, so the phase does not matter
   task automatic high_count(output int n);
      n = 0;
      repeat (512) begin
         @(posedge clock);
         if (pin_level[0] === 1'b1) n++;
      end
   endtask
   // bounded wait for an interrupt line, standing in for handler entry
   task automatic await_irq(input logic sel);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while ((sel ? overflow_irq : chan_irq[0]) !== 1'b1 && n < 600);
      check({31'h0, sel ? overflow_irq : chan_irq[0]}, 32'h1);
   endtask
   initial begin
      int n;
      logic [31:0] c1;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      bus(1'b0, timer_pkg::OFS_TIMER_CTL, 32'h0);
      check(rd, 32'h20);
      bus(1'b0, timer_pkg::OFS_PERIOD, 32'h0);
      check(rd, 32'hffff);
      bus(1'b0, timer_pkg::OFS_CH0_CTL, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 5'h1c, 32'h5a);
      bus(1'b0, 5'h1c, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, timer_pkg::OFS_TIMER_CTL, 32'h30);
      bus(1'b1, timer_pkg::OFS_PERIOD, 32'hff);
      foreach (rows[i]) begin
         if (rows[i].k == 1'b0) begin
            bus(1'b1, timer_pkg::OFS_TIMER_CTL, rows[i].a);
            bus(1'b0, timer_pkg::OFS_COUNT, 32'h0);
            c1 = rd;
            repeat (126) @(posedge clock);
            bus(1'b0, timer_pkg::OFS_COUNT, 32'h0);
            check((rd - c1) & 32'hff, rows[i].e);
         end else begin
            bus(1'b1, timer_pkg::OFS_CH0_VAL, rows[i].a);
            bus(1'b1, timer_pkg::OFS_CH0_CTL, rows[i].b);
            repeat (600) @(posedge clock);
            high_count(n);
            check(32'(n), rows[i].e);
         end
      end
      check({31'h0, chan_pin_oe[0]}, 32'h1);
      check({31'h0, overflow_irq}, 32'h1);
      // a write with no arming read must leave the flag set
      bus(1'b1, timer_pkg::OFS_TIMER_CTL, 32'h60);
      check({31'h0, overflow_irq}, 32'h1);
      bus(1'b0, timer_pkg::OFS_TIMER_CTL, 32'h0);
      check(rd & 32'h80, 32'h80);
      bus(1'b1, timer_pkg::OFS_TIMER_CTL, 32'h70);
      bus(1'b0, timer_pkg::OFS_COUNT, 32'h0);
      check(rd, 32'h0);
      check({31'h0, overflow_irq}, 32'h0);
      bus(1'b0, timer_pkg::OFS_TIMER_CTL, 32'h0);
      check(rd, 32'h60);
      bus(1'b0, timer_pkg::OFS_PERIOD, 32'h0);
      check(rd, 32'hff);
      bus(1'b1, timer_pkg::OFS_TIMER_CTL, 32'h40);
      bus(1'b1, timer_pkg::OFS_TIMER_CTL, 32'h60);
      bus(1'b0, timer_pkg::OFS_COUNT, 32'h0);
      c1 = rd;
      bus(1'b1, timer_pkg::OFS_CH1_CTL, 32'h44);
      bus(1'b1, timer_pkg::OFS_CH1_VAL, 32'h0);
      src_level[1] <= 1'b0;
      repeat (8) @(posedge clock);
      bus(1'b0, timer_pkg::OFS_CH1_VAL, 32'h0);
      check(rd, 32'h0);
      src_level[1] <= 1'b1;
      repeat (8) @(posedge clock);
      bus(1'b0, timer_pkg::OFS_CH1_VAL, 32'h0);
      check(rd, c1);
      check({31'h0, chan_irq[1]}, 32'h1);
      bus(1'b1, timer_pkg::OFS_CH1_CTL, 32'h1a);
      bus(1'b1, timer_pkg::OFS_CH0_VAL, 32'h40);
      bus(1'b1, timer_pkg::OFS_CH0_CTL, 32'h2a);
      bus(1'b1, timer_pkg::OFS_TIMER_CTL, 32'h0);
      repeat (600) @(posedge clock);
      high_count(n);
      check(32'(n), 32'd128);
      check({31'h0, chan_pin_oe[1]}, 32'h0);
      bus(1'b1, timer_pkg::OFS_CH1_VAL, 32'hc0);
      repeat (600) @(posedge clock);
      high_count(n);
      check(32'(n), 32'd384);
      bus(1'b0, timer_pkg::OFS_CH0_CTL, 32'h0);
      check(rd & 32'h80, 32'h80);
      bus(1'b1, timer_pkg::OFS_CH0_CTL, 32'h5a);
      await_irq(1'b0);
      bus(1'b1, timer_pkg::OFS_CH0_VAL, 32'h20);
      repeat (600) @(posedge clock);
      high_count(n);
      check(32'(n), 32'd64);
      bus(1'b0, timer_pkg::OFS_TIMER_CTL, 32'h0);
      bus(1'b1, timer_pkg::OFS_TIMER_CTL, 32'h40);
      await_irq(1'b1);
      bus(1'b1, timer_pkg::OFS_CH0_VAL, 32'ha0);
      repeat (600) @(posedge clock);
      high_count(n);
      check(32'(n), 32'd320);
      // second reset in mid-run: outputs idle, counter halted at zero
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      check({25'h0, overflow_irq, chan_pin_out, chan_pin_oe, chan_irq}, 32'h0);
      check({31'h0, hresp}, 32'h0);
      bus(1'b0, timer_pkg::OFS_TIMER_CTL, 32'h0);
      check(rd, 32'h20);
      bus(1'b0, timer_pkg::OFS_COUNT, 32'h0);
      check(rd, 32'h0);
      results();
   end
endmodule
